// [logic/isp_edge.sv]
// Per-source detector: level, falling, rising or both-edge with pending latch.
module isp_edge (
	input  wire logic       clk,       // Clock.
	input  wire logic       sys_rst,   // Async reset.
	input  wire logic       clk_en,    // Freezes state when low.
	input  wire logic       lvl,       // Synchronised pin level.
	input  wire logic [1:0] mode,      // Sense mode.
	input  wire logic       accept,    // CPU accepted this source.
	input  wire logic       cancel,    // Software cancel of the latch.
	input  wire logic       dbg_clr,   // Debug-port reset.
	output logic            req        // Request to the selector.
);
	logic prev_r;
	logic pend_r;
	logic hit;

	// Edge detection against the previous synchronised level.
	always_comb begin
		case (isp_pkg::isp_sense_t'(mode))
			isp_pkg::ISP_SENSE_FALL: hit = prev_r & ~lvl;
			isp_pkg::ISP_SENSE_RISE: hit = ~prev_r & lvl;
			isp_pkg::ISP_SENSE_BOTH: hit = prev_r ^ lvl;
			default:                 hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_r <= 1'b1;
		end else if (clk_en) begin
			prev_r <= lvl;
		end
	end

	// Pending latch; a new edge wins over accept or cancel.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_r <= 1'b0;
		end else if (clk_en) begin
			if (hit)
				pend_r <= 1'b1;
			else if (accept || cancel || dbg_clr ||
				 mode == isp_pkg::ISP_SENSE_LOW)
				pend_r <= 1'b0;
		end
	end

	// Low mode is a live, unlatched request.
	assign req = (mode == isp_pkg::ISP_SENSE_LOW) ? ~lvl : pend_r;
endmodule : isp_edge

// [logic/isp_pkg.sv]
// Package with register map, field layout, vectors and levels of the interrupt selector.
package isp_pkg;
	// Register indices on the plain register port (word per address).
	localparam logic [3:0] ADDR_CTRL0  = 4'h0; // intr_ctrl_reg0
	localparam logic [3:0] ADDR_SENSE  = 4'h1; // ext_sense_ctrl_reg
	localparam logic [3:0] ADDR_FLAGS  = 4'h2; // ext_req_flag_reg
	localparam logic [3:0] ADDR_PRIO_A = 4'h3; // priority_reg_a
	localparam logic [3:0] ADDR_PRIO_B = 4'h4; // priority_reg_b
	localparam logic [3:0] ADDR_PRIO_C = 4'h5; // first peripheral priority reg
	localparam logic [3:0] ADDR_PRIO_G = 4'h9; // last peripheral priority reg
	localparam logic [3:0] ADDR_STAT   = 4'hA; // selector status readback
	localparam int         NMI_EDGE_BIT = 8;   // nmi_edge_select in ctrl0
	localparam int         NMI_LVL_BIT  = 15;  // live pin level in ctrl0
	localparam logic [15:0] PRIO_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] SENSE_RESET = 16'h0000;
	// Sense modes of one external pin.
	typedef enum logic [1:0] {
		ISP_SENSE_LOW  = 2'b00,
		ISP_SENSE_FALL = 2'b01,
		ISP_SENSE_RISE = 2'b10,
		ISP_SENSE_BOTH = 2'b11
	} isp_sense_t;
	// Fixed vectors and levels.
	localparam logic [7:0] VEC_BRK   = 8'h0C; // 12
	localparam logic [7:0] VEC_NMI   = 8'h0B; // 11
	localparam logic [7:0] VEC_DBG   = 8'h0D; // 13
	localparam logic [7:0] VEC_EXT_LO = 8'h40; // 64
	localparam logic [7:0] VEC_EXT_HI = 8'h50; // 80
	localparam logic [7:0] VEC_PER   = 8'h54; // 84
	localparam logic [7:0] VEC_PER_LAST = 8'h6C; // 108
	localparam int         NUM_EXT   = 8;
	localparam int         NUM_PER   = 25;
	localparam logic [3:0] LVL_MAX   = 4'hF;   // 15
	localparam logic [4:0] LVL_NMI   = 5'h10;  // 16
	localparam logic [3:0] LVL_OFF   = 4'h0;
endpackage : isp_pkg

// [logic/isp_sync.sv]
// Two-flop synchroniser with clock enable.
module isp_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk,     // Clock.
	input  wire logic sys_rst, // Async reset.
	input  wire logic clk_en,  // Freezes state when low.
	input  wire logic d,       // Asynchronous input.
	output logic      q        // Synchronised output.
);
	logic meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else if (clk_en) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : isp_sync

// [logic/isp_top.sv]
// Interrupt source detection and priority selection towards the CPU core.
// How it works
// - Priority 0..15; zero never forwarded.
// - Non-maskable is level 16, always taken.
// - Non-maskable edge, polarity chosen by bit.
// - Non-maskable acceptance sets mask 15.
// - Two sense bits per external pin.
// - Four-bit priority per pin, two registers.
// - Low mode follows pin, no latch.
// - Low mode flag shows live request.
// - Falling, rising or both edges raise request.
// - Edge requests stay pending until accepted or cancelled.
// - Pin acceptance loads its programmed priority.
// - Peripheral vectors distinct, priority from registers.
// - Break unit: fixed 15, edge, held.
// - Debug port: fixed 15, edge, held.
// - Shared field ties go to smaller vector.
// - Priority fields reset to zero.
// - Equal levels use fixed default order.
// - Vectors 12 break, 11 nmi, 13 debug.
// - Pins map to vectors 64-67, 80-83.
// - Peripherals 84-108; serial channels share fields.
// - Accepted vector selects table entry.
// - Forward only when level exceeds mask.
// - Pending edges cleared by resets.
module isp_top (
	input  wire logic        clk,          // 40 MHz peripheral clock.
	input  wire logic        sys_rst,      // Power-on reset, async high.
	input  wire logic        clk_en,       // Freezes all state when low.
	input  wire logic        dbg_rst,      // Debug-port reset pulse.
	input  wire logic [7:0]  ext_pins,     // External request pins.
	input  wire logic        nmi_pin,      // Non-maskable pin.
	input  wire logic        brk_req,      // Break unit request level.
	input  wire logic        dbg_req,      // Debug-port interrupt level.
	input  wire logic [24:0] per_req,      // Peripheral request levels.
	input  wire logic [3:0]  mask_level,   // CPU mask_level_bits.
	input  wire logic        cpu_ack,      // CPU accepts presented request.
	input  wire logic [3:0]  reg_addr,     // Register index.
	input  wire logic [15:0] reg_wdata,    // Write data.
	input  wire logic        reg_wr,       // Write strobe.
	input  wire logic        reg_rd,       // Read strobe.
	output logic      [15:0] reg_rdata,    // Read data, cycle after strobe.
	output logic             irq_out,      // Request to the CPU.
	output logic      [7:0]  irq_vector,   // Vector of winner.
	output logic      [3:0]  irq_level,    // Mask level to load on accept.
	output logic      [9:0]  vec_offset    // Vector table byte offset.
);
	logic [15:0] ctrl_r;
	logic [15:0] sense_r;
	logic [15:0] prio_r [0:6];
	logic [7:0]  flag_seen_r;
	logic [7:0]  ext_s;
	logic        nmi_s, brk_s, dbg_s;
	logic [7:0]  ext_req;
	logic        nmi_req, brk_req_p, dbg_req_p;
	logic [7:0]  ext_acc, ext_cancel;
	logic        nmi_acc, brk_acc, dbg_acc;
	logic [24:0] per_vec_ok;
	logic [4:0]  best_lvl;
	logic [7:0]  best_vec;
	logic [5:0]  best_src;
	logic        fwd;
	logic        nmi_lvl;
	logic        brk_prev_r, dbg_prev_r;

	genvar g;
	generate
		for (g = 0; g < isp_pkg::NUM_EXT; g++) begin : g_ext
			isp_sync #(.RST_VAL(1'b1)) u_sync (
				.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
				.d(ext_pins[g]), .q(ext_s[g]));
			isp_edge u_det (
				.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
				.lvl(ext_s[g]), .mode(sense_r[2*g +: 2]),
				.accept(ext_acc[g]), .cancel(ext_cancel[g]),
				.dbg_clr(dbg_rst), .req(ext_req[g]));
		end
	endgenerate

	isp_sync #(.RST_VAL(1'b1)) u_nmi_sync (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.d(nmi_pin), .q(nmi_s));

	// polarity: 1 selects rising edge, 0 falling.
	assign nmi_lvl = nmi_s;
	isp_edge u_nmi_det (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.lvl(nmi_lvl),
		.mode(ctrl_r[isp_pkg::NMI_EDGE_BIT] ?
			2'(isp_pkg::ISP_SENSE_RISE) :
			2'(isp_pkg::ISP_SENSE_FALL)),
		.accept(nmi_acc), .cancel(1'b0),
		.dbg_clr(dbg_rst), .req(nmi_req));

	// Break and debug requests come from on-chip logic; no sync needed.
	assign brk_s = brk_req;
	assign dbg_s = dbg_req;

	logic brk_pend_r, dbg_pend_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			brk_prev_r <= 1'b0;
			dbg_prev_r <= 1'b0;
			brk_pend_r <= 1'b0;
			dbg_pend_r <= 1'b0;
		end else if (clk_en) begin
			brk_prev_r <= brk_s;
			dbg_prev_r <= dbg_s;
			// debug reset clears; new edge wins.
			if (brk_s && !brk_prev_r)
				brk_pend_r <= 1'b1;
			else if (brk_acc || dbg_rst)
				brk_pend_r <= 1'b0;
			if (dbg_s && !dbg_prev_r)
				dbg_pend_r <= 1'b1;
			else if (dbg_acc || dbg_rst)
				dbg_pend_r <= 1'b0;
		end
	end
	assign brk_req_p = brk_pend_r;
	assign dbg_req_p = dbg_pend_r;

	sequence s_brk_waiting;
		clk_en && brk_pend_r && !brk_acc && !dbg_rst;
	endsequence
	a_brk_held: assert property (@(posedge clk) disable iff (sys_rst)
		s_brk_waiting |=> brk_pend_r)
		else $error("break request lost before accept");

	// Priority field of a peripheral by its index 0..24.
	function automatic logic [3:0] per_prio(input int idx,
		input logic [15:0] c, input logic [15:0] d,
		input logic [15:0] e, input logic [15:0] f,
		input logic [15:0] gg);
		logic [3:0] p;
		p = 4'h0;
		if (idx < 4)
			p = c[15 - 4*idx -: 4];
		else if (idx < 16)
			// four serial sources share one field
			p = d[15 - 4*((idx - 4) / 4) -: 4];
		else if (idx < 18)
			p = e[15 - 4*(idx - 16) -: 4];
		else if (idx < 22)
			p = f[15 - 4*(idx - 18) -: 4];
		else if (idx == 22)
			p = gg[15:12];
		return p;
	endfunction : per_prio

	// Vector of peripheral index; 102 and 103 are skipped.
	function automatic logic [7:0] per_vec(input int idx);
		logic [7:0] v;
		v = 8'(idx) + isp_pkg::VEC_PER;
		if (idx >= 18)
			v = v + 8'h02;
		return v;
	endfunction : per_vec

	// Only 23 of 25 inputs have a vector; the spare two stay idle.
	assign per_vec_ok = 25'h07F_FFFF;

	// scan in default order; strict greater keeps earlier
	always_comb begin
		logic [3:0] p;
		p = 4'h0;
		best_lvl = 5'h00;
		best_vec = 8'h00;
		best_src = 6'h00;
		// fixed vectors come from the package.
		if (brk_req_p) begin
			best_lvl = {1'b0, isp_pkg::LVL_MAX};
			best_vec = isp_pkg::VEC_BRK;
			best_src = 6'd1;
		end
		if (nmi_req && isp_pkg::LVL_NMI > best_lvl) begin
			best_lvl = isp_pkg::LVL_NMI;
			best_vec = isp_pkg::VEC_NMI;
			best_src = 6'd2;
		end
		if (dbg_req_p && {1'b0, isp_pkg::LVL_MAX} > best_lvl) begin
			best_lvl = {1'b0, isp_pkg::LVL_MAX};
			best_vec = isp_pkg::VEC_DBG;
			best_src = 6'd3;
		end
		for (int i = 0; i < isp_pkg::NUM_EXT; i++) begin
			p = (i < 4) ? prio_r[0][15 - 4*i -: 4] :
				prio_r[1][15 - 4*(i - 4) -: 4];
			if (ext_req[i] && p != isp_pkg::LVL_OFF &&
			    {1'b0, p} > best_lvl) begin
				best_lvl = {1'b0, p};
				best_vec = (i < 4) ? isp_pkg::VEC_EXT_LO + 8'(i) :
					isp_pkg::VEC_EXT_HI + 8'(i - 4);
				best_src = 6'(4 + i);
			end
		end
		for (int j = 0; j < isp_pkg::NUM_PER; j++) begin
			p = per_prio(j, prio_r[2], prio_r[3], prio_r[4],
				prio_r[5], prio_r[6]);
			if (per_req[j] && per_vec_ok[j] && p != isp_pkg::LVL_OFF &&
			    {1'b0, p} > best_lvl) begin
				best_lvl = {1'b0, p};
				best_vec = per_vec(j);
				best_src = 6'(12 + j);
			end
		end
	end

	// compare with mask; non-maskable always passes
	assign fwd = (best_src != 6'd0) &&
		(best_lvl[4] || best_lvl[3:0] > mask_level);

	// outputs registered; offset is vector times four
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out    <= 1'b0;
			irq_vector <= 8'h00;
			irq_level  <= 4'h0;
			vec_offset <= 10'h000;
		end else if (clk_en) begin
			irq_out    <= fwd && !cpu_ack;
			irq_vector <= best_vec;
			// level to load; 16 loads 15
			irq_level  <= best_lvl[4] ? isp_pkg::LVL_MAX : best_lvl[3:0];
			vec_offset <= {best_vec, 2'b00};
		end
	end

	// Accept pulses go back to the pending latch of the presented winner.
	logic [5:0] shown_src_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			shown_src_r <= 6'h00;
		else if (clk_en)
			shown_src_r <= fwd ? best_src : 6'h00;
	end
	wire ack_ok = cpu_ack && irq_out;
	assign brk_acc = ack_ok && shown_src_r == 6'd1;
	assign nmi_acc = ack_ok && shown_src_r == 6'd2;
	assign dbg_acc = ack_ok && shown_src_r == 6'd3;
	always_comb begin
		for (int k = 0; k < isp_pkg::NUM_EXT; k++)
			ext_acc[k] = ack_ok && shown_src_r == 6'(4 + k);
	end

	// cancel needs a prior read of 1
	always_comb begin
		for (int k = 0; k < isp_pkg::NUM_EXT; k++)
			ext_cancel[k] = reg_wr && reg_addr == isp_pkg::ADDR_FLAGS &&
				!reg_wdata[k] && flag_seen_r[k];
	end

	// Remember flags read as 1 until the next flag read or flag write.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			flag_seen_r <= 8'h00;
		else if (clk_en) begin
			if (reg_rd && reg_addr == isp_pkg::ADDR_FLAGS)
				flag_seen_r <= ext_req;
			else if (reg_wr && reg_addr == isp_pkg::ADDR_FLAGS)
				flag_seen_r <= 8'h00;
		end
	end

	// register writes; priority fields reset to zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r  <= isp_pkg::CTRL_RESET;
			sense_r <= isp_pkg::SENSE_RESET;
			for (int r = 0; r < 7; r++)
				prio_r[r] <= isp_pkg::PRIO_RESET;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				isp_pkg::ADDR_CTRL0: ctrl_r  <= reg_wdata;
				isp_pkg::ADDR_SENSE: sense_r <= reg_wdata;
				isp_pkg::ADDR_PRIO_A, isp_pkg::ADDR_PRIO_B,
				4'h5, 4'h6, 4'h7, 4'h8, isp_pkg::ADDR_PRIO_G:
					prio_r[3'(reg_addr - isp_pkg::ADDR_PRIO_A)] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// flags read live request, one cycle later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (clk_en) begin
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
					isp_pkg::ADDR_CTRL0:
						reg_rdata <= {nmi_s, 6'h00,
							ctrl_r[isp_pkg::NMI_EDGE_BIT], 8'h00};
					isp_pkg::ADDR_SENSE: reg_rdata <= sense_r;
					isp_pkg::ADDR_FLAGS: reg_rdata <= {8'h00, ext_req};
					isp_pkg::ADDR_PRIO_A, isp_pkg::ADDR_PRIO_B,
					4'h5, 4'h6, 4'h7, 4'h8, isp_pkg::ADDR_PRIO_G:
						reg_rdata <= prio_r[3'(reg_addr - isp_pkg::ADDR_PRIO_A)];
					isp_pkg::ADDR_STAT:
						reg_rdata <= {3'h0, best_lvl, best_vec};
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Assertions.
	a_zero_never_fwd: assert property (@(posedge clk) disable iff (sys_rst)
		(fwd && !best_lvl[4]) |-> best_lvl[3:0] != 4'h0)
		else $error("zero level forwarded");
	a_mask_strict: assert property (@(posedge clk) disable iff (sys_rst)
		(fwd && !best_lvl[4]) |-> best_lvl[3:0] > mask_level)
		else $error("level not above mask");
	a_nmi_always: assert property (@(posedge clk) disable iff (sys_rst)
		(clk_en && nmi_req && !cpu_ack) |=> irq_out && irq_vector == 8'd11)
		else $error("nmi not presented");
	a_nmi_level: assert property (@(posedge clk) disable iff (sys_rst)
		(irq_out && irq_vector == 8'd11) |-> irq_level == 4'hF)
		else $error("nmi level wrong");
	a_offset_vec: assert property (@(posedge clk) disable iff (sys_rst)
		vec_offset == {irq_vector, 2'b00})
		else $error("vector offset mismatch");
	a_dbg_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(clk_en && dbg_rst && !brk_s) |=> !brk_pend_r)
		else $error("debug reset left break pending");
	a_brk_vec: assert property (@(posedge clk) disable iff (sys_rst)
		(best_src == 6'd1) |-> best_vec == 8'd12 && best_lvl == 5'd15)
		else $error("break vector wrong");
	a_low_live: assert property (@(posedge clk) disable iff (sys_rst)
		(sense_r[1:0] == 2'b00) |-> ext_req[0] == !ext_s[0])
		else $error("low mode not live");
endmodule : isp_top

// [verif/interrupt_source_priority_bench.sv]
// Self-checking bench of the interrupt source selector.
module interrupt_source_priority_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	// The non-maskable pin idles high, the level its synchroniser resets to,
	// so that release of reset shows no false falling edge.
	logic dbg_rst = 1'b0, nmi_pin = 1'b1, brk_req = 1'b0, dbg_req = 1'b0;
	logic [7:0] ext_pins = 8'hFF;
	logic [24:0] per_req = '0;
	logic [3:0] reg_addr = 4'h0, mask_level, irq_level, mask_in = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_ack, irq_out;
	logic ack_en = 1'b0, mask_wr = 1'b0;
	logic [7:0] irq_vector;
	logic [9:0] vec_offset;
	int n_fail = 0, compares = 0;

	// Half period of the 40 MHz clock.
	always #12.5 clk = ~clk;

	isp_top isp_top_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.dbg_rst(dbg_rst), .ext_pins(ext_pins), .nmi_pin(nmi_pin),
		.brk_req(brk_req), .dbg_req(dbg_req), .per_req(per_req),
		.mask_level(mask_level), .cpu_ack(cpu_ack), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_out(irq_out),
		.irq_vector(irq_vector), .irq_level(irq_level),
		.vec_offset(vec_offset));

	isp_cpu_model isp_cpu_model_inst (.clk(clk), .sys_rst(sys_rst),
		.irq_out(irq_out), .irq_level(irq_level), .ack_en(ack_en),
		.mask_wr(mask_wr), .mask_in(mask_in), .mask_level(mask_level),
		.cpu_ack(cpu_ack));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask : rd

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		rd(a, d);
		chk(d, exp);
	endtask : rd_chk

	task automatic set_mask(input logic [3:0] m);
		@(posedge clk);
		mask_in <= m;
		mask_wr <= 1'b1;
		@(posedge clk);
		mask_wr <= 1'b0;
	endtask : set_mask

	// Waits a bounded time for a request, then checks what it shows.
	task automatic chk_irq(input logic [7:0] v, input logic [3:0] l);
		for (int i = 0; i < 12 && irq_out !== 1'b1; i++) begin
			@(negedge clk);
		end
		@(negedge clk);
		chk({15'h0000, irq_out}, 16'h0001);
		chk({8'h00, irq_vector}, {8'h00, v});
		chk({12'h000, irq_level}, {12'h000, l});
		chk({6'h00, vec_offset}, {6'h00, v, 2'b00});
	endtask : chk_irq

	task automatic chk_quiet();
		repeat (6) @(negedge clk);
		chk({15'h0000, irq_out}, 16'h0000);
	endtask : chk_quiet

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Tests take well under 2000 cycles.
	initial begin
		#(25 * 5000);
		n_fail++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 3; a <= 9; a++) begin
			rd_chk(a[3:0], 16'h0000);
		end
		rd_chk(isp_pkg::ADDR_SENSE, 16'h0000);
		rd_chk(4'hB, 16'h0000);
		$display("test 1 done");
		// Level sense with zero priority, then a real priority.
		@(posedge clk) ext_pins[0] <= 1'b0;
		chk_quiet();
		wr(isp_pkg::ADDR_PRIO_A, 16'h5000);
		chk_irq(8'd64, 4'h5);
		rd_chk(isp_pkg::ADDR_FLAGS, 16'h0001);
		set_mask(4'h5);
		chk_quiet();
		set_mask(4'h4);
		chk_irq(8'd64, 4'h5);
		@(posedge clk) ext_pins[0] <= 1'b1;
		chk_quiet();
		rd_chk(isp_pkg::ADDR_FLAGS, 16'h0000);
		set_mask(4'h0);
		$display("test 2 done");
		// Edge modes on pin 4, each held and then cancelled.
		wr(isp_pkg::ADDR_PRIO_B, 16'h9000);
		for (int m = 1; m <= 3; m++) begin
			wr(isp_pkg::ADDR_SENSE, 16'(m) << 8);
			@(posedge clk) ext_pins[4] <= 1'b0;
			repeat (6) @(negedge clk);
			chk({15'h0000, irq_out}, {15'h0000, m != 2});
			@(posedge clk) ext_pins[4] <= 1'b1;
			chk_irq(8'd80, 4'h9);
			rd_chk(isp_pkg::ADDR_FLAGS, 16'h0010);
			wr(isp_pkg::ADDR_FLAGS, 16'h00EF);
			chk_quiet();
			rd_chk(isp_pkg::ADDR_FLAGS, 16'h0000);
		end
		$display("test 3 done");
		// Acceptance loads the mask and clears the pending latch.
		wr(isp_pkg::ADDR_SENSE, 16'h0100);
		ack_en <= 1'b1;
		@(posedge clk) ext_pins[4] <= 1'b0;
		repeat (10) @(negedge clk);
		chk({12'h000, mask_level}, 16'h0009);
		rd_chk(isp_pkg::ADDR_FLAGS, 16'h0000);
		ack_en <= 1'b0;
		@(posedge clk) ext_pins[4] <= 1'b1;
		set_mask(4'h0);
		$display("test 4 done");
		// Non-maskable on each edge polarity, above the mask.
		set_mask(4'hF);
		@(posedge clk) nmi_pin <= 1'b0;
		chk_irq(8'd11, 4'hF);
		ack_en <= 1'b1;
		wr(isp_pkg::ADDR_CTRL0, 16'h0100);
		ack_en <= 1'b0;
		chk_quiet();
		set_mask(4'h3);
		@(posedge clk) nmi_pin <= 1'b1;
		chk_irq(8'd11, 4'hF);
		ack_en <= 1'b1;
		@(posedge clk) nmi_pin <= 1'b0;
		chk_quiet();
		chk({12'h000, mask_level}, 16'h000F);
		ack_en <= 1'b0;
		set_mask(4'h0);
		$display("test 5 done");
		// Break and debug together: default order, then debug reset.
		@(posedge clk);
		brk_req <= 1'b1;
		dbg_req <= 1'b1;
		chk_irq(8'd12, 4'hF);
		ack_en <= 1'b1;
		for (int i = 0; i < 8 && cpu_ack !== 1'b1; i++) @(negedge clk);
		ack_en <= 1'b0;
		chk_quiet();
		set_mask(4'h0);
		chk_irq(8'd13, 4'hF);
		@(posedge clk) dbg_rst <= 1'b1;
		@(posedge clk) dbg_rst <= 1'b0;
		chk_quiet();
		@(posedge clk);
		brk_req <= 1'b0;
		dbg_req <= 1'b0;
		$display("test 6 done");
		// Two sources of one serial channel share a field.
		wr(4'h6, 16'h7000);
		@(posedge clk) per_req[5:4] <= 2'b11;
		chk_irq(8'd88, 4'h7);
		@(posedge clk) per_req[4] <= 1'b0;
		repeat (4) @(negedge clk);
		chk_irq(8'd89, 4'h7);
		@(posedge clk) per_req[5] <= 1'b0;
		chk_quiet();
		$display("test 7 done");
		// A low clock enable freezes detection until it rises again.
		@(posedge clk) clk_en <= 1'b0;
		@(posedge clk) ext_pins[4] <= 1'b0;
		chk_quiet();
		@(posedge clk) clk_en <= 1'b1;
		chk_irq(8'd80, 4'h9);
		rd_chk(isp_pkg::ADDR_FLAGS, 16'h0010);
		wr(isp_pkg::ADDR_FLAGS, 16'h0000);
		chk_quiet();
		@(posedge clk) ext_pins[4] <= 1'b1;
		$display("test 8 done");
		print_verdict();
	end
endmodule : interrupt_source_priority_bench

// [verif/isp_cpu_model.sv]
// Behavioural model of the CPU core that takes requests from the selector.
module isp_cpu_model (
	input  wire logic       clk,        // Peripheral clock.
	input  wire logic       sys_rst,    // Async reset, high.
	input  wire logic       irq_out,    // Request from the selector.
	input  wire logic [3:0] irq_level,  // Level shown with the request.
	input  wire logic       ack_en,     // Bench lets the core accept.
	input  wire logic       mask_wr,    // Bench loads a mask value.
	input  wire logic [3:0] mask_in,    // Mask value to load.
	output logic      [3:0] mask_level, // Current core mask.
	output logic            cpu_ack     // One-cycle acceptance pulse.
);
	timeunit 1ns;
	timeprecision 1ps;

	// The pulse lasts one cycle, so one request is never taken twice.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_ack <= 1'b0;
		end else begin
			cpu_ack <= irq_out && ack_en && !cpu_ack;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_level <= 4'h0;
		end else if (cpu_ack) begin
			mask_level <= irq_level;
		end else if (mask_wr) begin
			mask_level <= mask_in;
		end
	end
endmodule : isp_cpu_model
